// ===== core/uad_pkg.sv
// Constants shared by the address-detect and pin wake-up qualifier.
// Assumes a single 25 MHz clock and an AXI4-Lite master on the register side.
package uad_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFFS = 8'h00; // Control word
   localparam logic [ADDR_W-1:0] STAT_OFFS = 8'h04; // Status word
   localparam logic [ADDR_W-1:0] DATA_OFFS = 8'h08; // Received word

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_W = 10;
   localparam int CB_ADDR_EN = 0;  // address_match_enable
   localparam int CB_NINE = 1;     // nine_bit_select
   localparam int CB_PARITY = 2;   // parity_on
   localparam int CB_WAKE = 3;     // pin_wake_enable
   localparam int CB_PORT = 4;     // port_enable
   localparam int CB_RXON = 5;     // receiver_on
   localparam int CB_RXIRQ = 6;    // rx_irq_unmask
   localparam int CB_UARTIRQ = 7;  // uart_irq_unmask
   localparam int CB_MFIRQ = 8;    // multi_function_irq_unmask
   localparam int CB_GLOBIRQ = 9;  // global_irq_unmask
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

   // ----------------------------------------------------------------
   // Status field positions
   // ----------------------------------------------------------------
   localparam int SB_FLAG = 0;     // rx_word_available_flag
   localparam int SB_PW_LO = 1;    // Power state, two bits

   // ----------------------------------------------------------------
   // Received word
   // ----------------------------------------------------------------
   localparam int WORD_W = 9;
   localparam logic [WORD_W-1:0] DATA_RST = 9'h000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int STARTUP_NS = 1000; // Clock start-up after a wake-up
   localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] STARTUP_CNT = CNT_W'(STARTUP_CYC);
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Power states
   typedef enum logic [1:0] {
      PW_RUN = 2'b00,   // UART clock running
      PW_OFF = 2'b01,   // UART clock gated off
      PW_START = 2'b10  // Start-up interval after a pin wake-up
   } uad_pw_e;

endpackage : uad_pkg

// ===== core/uad_addr_wake.sv
// Address-detect receive interrupt qualifier and pin wake-up logic of a UART.
// Assumes the receiver delivers words on aclk, the power logic drives
// uart_clk_on on aclk, and the serial pin is asynchronous.
`timescale 1ns/1ps

// Summary of operation
// - Address mode: interrupt only when top bit set
// - Top bit is ninth or eighth by length
// - Top bit one marks an address word
// - Address mode off: interrupt on every word
// - Address interrupt needs all three masks open
// - Clock off pauses transmission, resumes later
// - Clock off suspends reception, resumes later
// - Power-down keeps the control register unless written
// - Enabled falling pin edge raises wake interrupt
// - Pin data ignored during start-up interval
// - Closed masks: wake only, no interrupt
// - Wake interrupt only after start-up elapsed
// - No own flags for address or wake
// - Word flag set on data, cleared status-data
module uad_addr_wake
   import uad_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Receiver word delivery
   input wire logic rx_word_valid,
   input wire logic [WORD_W-1:0] rx_word,
   // Power control and serial pin
   input wire logic uart_clk_on,
   input wire logic shared_serial_pin,
   // Outputs to interrupt, power and transfer logic
   output logic uart_irq,
   output logic wake_event,
   output logic xfer_run,
   output logic rx_ignore,
   output logic rx_is_address,
   output logic cfg_nine_bit,
   output logic cfg_parity_on
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awready;               // Write address ready
      logic wready;                // Write data ready
      logic aw_got;                // Write address held
      logic w_got;                 // Write data held
      logic [ADDR_W-1:0] waddr;    // Held write address
      logic [31:0] wdata;          // Held write data
      logic [3:0] wstrb;           // Held byte strobes
      logic bvalid;                // Write response pending
      logic [1:0] bresp;           // Write response code
      logic arready;               // Read address ready
      logic rvalid;                // Read data pending
      logic [31:0] rdata;          // Read data
      logic [1:0] rresp;           // Read response code
      logic [CTRL_W-1:0] ctrl;     // Control register
      logic [WORD_W-1:0] data;     // Last accepted word
      logic flag;                  // Word available
      logic seen;                  // Status read since last data read
      logic is_addr;               // Last word was an address
      logic pin_s1;                // Pin synchroniser, first stage
      logic pin_s2;                // Pin synchroniser, second stage
      logic pin_s3;                // Delayed copy for edge detection
      uad_pw_e pw;                 // Power state
      logic [CNT_W-1:0] cnt;       // Start-up countdown
      logic irq;                   // Interrupt request pulse
      logic wake;                  // Wake event pulse
      logic run;                   // Transfers may advance
      logic ignore;                // Receiver input blocked
   } uad_state_s;

   uad_state_s s_q;  // Registered state
   uad_state_s s_d;  // Next state

   // Helpers shared with the checks
   logic masks_ok;   // All three upstream masks open
   logic wake_armed; // Wake-up enables all set
   logic pin_fall;   // Synchronised falling edge on the pin
   logic rx_accept;  // Receiver word taken this cycle
   logic top_bit;    // Qualifying top bit of the incoming word
   logic wr_do;      // Register write performed this cycle
   logic rd_data;    // Data register read this cycle

   // ----------------------------------------------------------------
   // Combinational helpers
   // ----------------------------------------------------------------
   // Qualifier terms from the control register, received word, pin and bus
   always_comb begin
      masks_ok = s_q.ctrl[CB_UARTIRQ] & s_q.ctrl[CB_MFIRQ] & s_q.ctrl[CB_GLOBIRQ];
      wake_armed = s_q.ctrl[CB_WAKE] & s_q.ctrl[CB_PORT] & s_q.ctrl[CB_RXON]
                   & s_q.ctrl[CB_RXIRQ];
      pin_fall = s_q.pin_s3 & ~s_q.pin_s2;
      top_bit = s_q.ctrl[CB_NINE] ? rx_word[8] : rx_word[7];
      rx_accept = rx_word_valid & s_q.ctrl[CB_RXON] & (s_q.pw != PW_START);
      rd_data = s_q.arready & s_axi_arvalid & (s_axi_araddr == DATA_OFFS);
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      wr_do = 1'b0;
      s_d.irq = 1'b0;
      s_d.wake = 1'b0;

      // Pin synchroniser, clock-independent of the UART clock gate
      s_d.pin_s1 = shared_serial_pin;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.pin_s3 = s_q.pin_s2;

      // Write response retires
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Write address taken
      if (s_q.awready && s_axi_awvalid) begin
         s_d.aw_got = 1'b1;
         s_d.waddr = s_axi_awaddr;
      end
      // Write data taken
      if (s_q.wready && s_axi_wvalid) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      // Both halves held: perform the write; only the bus changes the control register
      if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
         wr_do = 1'b1;
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         if (s_d.waddr == CTRL_OFFS) begin
            if (s_d.wstrb[0]) begin
               s_d.ctrl[7:0] = s_d.wdata[7:0];
            end
            if (s_d.wstrb[1]) begin
               s_d.ctrl[CTRL_W-1:8] = s_d.wdata[CTRL_W-1:8];
            end
         end else if ((s_d.waddr != STAT_OFFS) && (s_d.waddr != DATA_OFFS)) begin
            s_d.bresp = RESP_DECERR; // Unmapped address
         end
      end

      // Read data retires
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // Read address taken and decoded
      if (s_q.arready && s_axi_arvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            CTRL_OFFS: begin
               s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
            end
            STAT_OFFS: begin
               // Status access arms the flag clear
               s_d.rdata[SB_FLAG] = s_q.flag;
               s_d.rdata[SB_PW_LO+1:SB_PW_LO] = s_q.pw;
               s_d.seen = 1'b1;
            end
            DATA_OFFS: begin
               // Data read after a status access clears the flag
               s_d.rdata[WORD_W-1:0] = s_q.data;
               if (s_q.seen) begin
                  s_d.flag = 1'b0;
                  s_d.seen = 1'b0;
               end
            end
            default: begin
               s_d.rresp = RESP_DECERR; // Unmapped address
            end
         endcase
      end

      // Receiver word; placed after the clear so that setting wins
      if (rx_accept) begin
         s_d.data = rx_word;
         s_d.flag = 1'b1;
         s_d.is_addr = top_bit;
         // Qualified interrupt, no flag of its own
         if (s_q.ctrl[CB_RXIRQ] && masks_ok
             && (!s_q.ctrl[CB_ADDR_EN] || top_bit)) begin
            s_d.irq = 1'b1;
         end
      end

      // Power state machine
      case (s_q.pw)
         PW_RUN: begin
            // Clock gated: enter power-down
            if (!uart_clk_on) begin
               s_d.pw = PW_OFF;
            end
         end
         PW_OFF: begin
            // Falling edge with wake enabled starts the start-up interval
            if (wake_armed && pin_fall) begin
               s_d.wake = 1'b1;
               s_d.pw = PW_START;
               s_d.cnt = STARTUP_CNT;
            end else if (uart_clk_on) begin
               s_d.pw = PW_RUN;
            end
         end
         PW_START: begin
            // Interrupt only once the interval has run out
            if (s_q.cnt == 8'h01) begin
               s_d.pw = PW_RUN;
               s_d.irq = masks_ok;
            end else begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
         end
         default: begin
            s_d.pw = PW_RUN;
         end
      endcase

      // Transfers advance only with the clock on; progress is held outside
      s_d.run = uart_clk_on & s_q.ctrl[CB_PORT];
      s_d.ignore = (s_d.pw == PW_START);

      // Bus readies follow the held halves
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '{awready: 1'b0, wready: 1'b0, aw_got: 1'b0, w_got: 1'b0,
                  waddr: 8'h00, wdata: 32'h0000_0000, wstrb: 4'h0,
                  bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b0,
                  rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY,
                  ctrl: CTRL_RST, data: DATA_RST, flag: 1'b0, seen: 1'b0,
                  is_addr: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1, pin_s3: 1'b1,
                  pw: PW_RUN, cnt: CNT_RST, irq: 1'b0, wake: 1'b0,
                  run: 1'b0, ignore: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign uart_irq = s_q.irq;
   assign wake_event = s_q.wake;
   assign xfer_run = s_q.run;
   assign rx_ignore = s_q.ignore;
   assign rx_is_address = s_q.is_addr;
   assign cfg_nine_bit = s_q.ctrl[CB_NINE];
   assign cfg_parity_on = s_q.ctrl[CB_PARITY];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Any request pulse implies open masks one cycle earlier
   irq_masks_a: assert property (s_q.irq |-> $past(masks_ok))
      else $error("interrupt with a mask closed");
   // Data word in address mode gives no interrupt
   addr_qual_a: assert property (rx_accept && s_q.ctrl[CB_ADDR_EN] && !top_bit
      |=> !s_q.irq)
      else $error("data word raised interrupt in address mode");
   // Top bit chosen by word length
   top_bit_a: assert property (rx_accept |=> s_q.is_addr ==
      $past(s_q.ctrl[CB_NINE] ? rx_word[8] : rx_word[7]))
      else $error("wrong qualifying bit");
   // Plain mode: every word interrupts
   plain_irq_a: assert property (rx_accept && !s_q.ctrl[CB_ADDR_EN]
      && s_q.ctrl[CB_RXIRQ] && masks_ok |=> s_q.irq)
      else $error("word without interrupt");
   // Flag set and clear order
   flag_set_a: assert property (rx_accept |=> s_q.flag)
      else $error("flag not set by word");
   flag_clr_a: assert property (rd_data && s_q.seen && !rx_accept
      |=> !s_q.flag && !s_q.seen)
      else $error("flag not cleared by status then data");
   // Wake edge starts start-up
   wake_edge_a: assert property (s_q.pw == PW_OFF && wake_armed && pin_fall
      |=> s_q.wake && s_q.pw == PW_START)
      else $error("wake edge missed");
   // No interrupt early in start-up, and it lasts the full count
   start_quiet_a: assert property ($rose(s_q.pw == PW_START)
      |-> (!s_q.irq && s_q.ignore)[*8])
      else $error("interrupt inside start-up");
   start_len_a: assert property ($fell(s_q.pw == PW_START)
      |-> $past(s_q.cnt) == 8'h01)
      else $error("start-up cut short");
   // Ignored words leave the data unchanged
   ignore_a: assert property (s_q.pw == PW_START |=> $stable(s_q.data))
      else $error("word taken during start-up");
   // Clock off stops transfers and keeps the control register when not written
   pause_a: assert property (!uart_clk_on |=> !s_q.run)
      else $error("transfer ran with clock off");
   regs_keep_a: assert property (!uart_clk_on && !wr_do |=> $stable(s_q.ctrl))
      else $error("register changed in power-down");

   addr_irq_c: cover property (rx_accept && s_q.ctrl[CB_ADDR_EN] && top_bit ##1 s_q.irq);
   wake_irq_c: cover property (s_q.wake ##[1:40] s_q.irq);
   flag_clr_c: cover property (rd_data && s_q.seen ##1 !s_q.flag);

endmodule : uad_addr_wake

// ===== tb/uad_far_tx.sv
// Model of the remote serial sender on the shared pin and of its receiver path.
// Assumes one aclk domain; the pin idles high as it would with a pull-up.
`timescale 1ns/1ps

module uad_far_tx
   import uad_pkg::*;
#(
   parameter int LOW_CYC = 8 // Cycles the pin stays low in each frame
)(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Frame request from the bench
   input wire logic start,
   input wire logic [WORD_W-1:0] word_in,
   // Pin and word delivery
   output logic pin,
   output logic word_valid,
   output logic [WORD_W-1:0] word
);
   logic [7:0] cnt_q; // Frame progress, zero while idle

   // Frame sequencer: pin low for the start part, then hand over the word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 8'h00;
         pin <= 1'b1;
         word_valid <= 1'b0;
         word <= 9'h000;
      end else begin
         word_valid <= 1'b0;
         word <= ~word; // Word lines invert every cycle outside a delivery
         if (cnt_q == 8'h00) begin
            if (start) begin
               cnt_q <= 8'h01;
               pin <= 1'b0;
            end
         end else if (cnt_q == 8'(LOW_CYC + 2)) begin
            cnt_q <= 8'h00;
            word_valid <= 1'b1;
            word <= word_in;
         end else begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(LOW_CYC)) pin <= 1'b1; // Back to idle level
         end
      end
   end
endmodule : uad_far_tx

// ===== tb/tb.sv
// Self-checking bench for the address-detect and pin wake-up qualifier.
// Assumes uad_pkg and the far-side model uad_far_tx are compiled first.
`timescale 1ns/1ps

module tb
   import uad_pkg::*;
;
   typedef struct {logic [CTRL_W-1:0] ctrl; logic [WORD_W-1:0] word; logic irq;} uad_row_s;
   logic aclk, aresetn, uart_clk_on, frame_start;
   logic [WORD_W-1:0] frame_word, rx_word;
   logic rx_word_valid, shared_serial_pin;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp;
   logic uart_irq, wake_event, xfer_run, rx_ignore, rx_is_address, cfg_nine_bit, cfg_parity_on;
   logic top;
   logic [CTRL_W-1:0] wctrl;
   int num_errors, num_checks, irq_cnt, wake_cnt, base_irq, base_wake;
   // Address mode, length and mask cases; parity kept off throughout
   uad_row_s rows [10] = '{'{10'h3f0, 9'h000, 1'b1}, '{10'h3f0, 9'h080, 1'b1},
      '{10'h3f1, 9'h080, 1'b1}, '{10'h3f1, 9'h100, 1'b0}, '{10'h3f3, 9'h100, 1'b1},
      '{10'h3f3, 9'h080, 1'b0}, '{10'h1f3, 9'h1ff, 1'b0}, '{10'h2f3, 9'h1ff, 1'b0},
      '{10'h373, 9'h1ff, 1'b0}, '{10'h3b1, 9'h0ff, 1'b0}};

   always #20 aclk = ~aclk;

   // Pulse counters, sampled mid-cycle where the pulses are settled
   always @(negedge aclk) begin
      if (uart_irq === 1'b1) irq_cnt++;
      if (wake_event === 1'b1) wake_cnt++;
   end

   uad_far_tx u_far (.aclk(aclk), .aresetn(aresetn), .start(frame_start),
      .word_in(frame_word), .pin(shared_serial_pin), .word_valid(rx_word_valid),
      .word(rx_word));

   uad_addr_wake u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
      .uart_clk_on(uart_clk_on), .shared_serial_pin(shared_serial_pin),
      .uart_irq(uart_irq), .wake_event(wake_event), .xfer_run(xfer_run),
      .rx_ignore(rx_ignore), .rx_is_address(rx_is_address), .cfg_nine_bit(cfg_nine_bit),
      .cfg_parity_on(cfg_parity_on));

   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // AXI4-Lite write; readies looked at mid-cycle, released after the taking edge
   task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                            output logic [1:0] resp);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 50 && !b_t; i++) begin
         @(negedge aclk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         b_t = s_axi_bvalid & s_axi_bready;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) s_axi_bready <= 1'b0;
      end
      // A write that never answers ends the run
      if (!b_t) begin
         num_errors++;
         finish_test();
      end
   endtask : axi_write

   // AXI4-Lite read in the same manner
   task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                           output logic [1:0] resp);
      logic ar_t, r_t;
      r_t = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 50 && !r_t; i++) begin
         @(negedge aclk);
         ar_t = s_axi_arvalid & s_axi_arready;
         r_t = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) s_axi_rready <= 1'b0;
      end
      // A read that never answers ends the run
      if (!r_t) begin
         num_errors++;
         finish_test();
      end
   endtask : axi_read

   // One frame from the far side
   task automatic send(input logic [WORD_W-1:0] w);
      @(posedge aclk);
      frame_start <= 1'b1;
      frame_word <= w;
      @(posedge aclk);
      frame_start <= 1'b0;
   endtask : send

   // Verdict and end of run
   task automatic finish_test();
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      {aclk, aresetn, frame_start, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
      {frame_word, s_axi_wdata} = 41'h0;
      s_axi_wstrb = 4'hf;
      uart_clk_on = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(CTRL_OFFS, rdat, rrsp);
      check("ctrl reset", rdat, 32'(CTRL_RST));
      axi_read(STAT_OFFS, rdat, rrsp);
      check("status reset", rdat, 32'h0);
      foreach (rows[i]) begin
         axi_write(CTRL_OFFS, 32'(rows[i].ctrl), wrsp);
         axi_read(CTRL_OFFS, rdat, rrsp);
         check("ctrl readback", rdat, 32'(rows[i].ctrl));
         base_irq = irq_cnt;
         send(rows[i].word);
         repeat (16) @(posedge aclk);
         check("irq count", irq_cnt - base_irq, 32'(rows[i].irq));
         top = rows[i].ctrl[CB_NINE] ? rows[i].word[8] : rows[i].word[7];
         check("address word", 32'(rx_is_address), 32'(top));
         check("nine bit cfg", 32'(cfg_nine_bit), 32'(rows[i].ctrl[CB_NINE]));
         axi_read(STAT_OFFS, rdat, rrsp);
         check("flag set", 32'(rdat[SB_FLAG]), 32'h1);
         axi_read(DATA_OFFS, rdat, rrsp);
         check("data word", rdat, 32'(rows[i].word));
         axi_read(STAT_OFFS, rdat, rrsp);
         check("flag clear", 32'(rdat[SB_FLAG]), 32'h0);
      end
      // Unmapped and read-only places
      axi_read(8'h0c, rdat, rrsp);
      check("unmapped rresp", 32'(rrsp), 32'(RESP_DECERR));
      check("unmapped rdata", rdat, 32'h0);
      axi_write(8'h0c, 32'hffff_ffff, wrsp);
      check("unmapped bresp", 32'(wrsp), 32'(RESP_DECERR));
      axi_write(STAT_OFFS, 32'hffff_ffff, wrsp);
      check("status bresp", 32'(wrsp), 32'(RESP_OKAY));
      axi_read(STAT_OFFS, rdat, rrsp);
      check("status read only", rdat, 32'h0);
      axi_write(CTRL_OFFS, 32'h0000_0004, wrsp);
      repeat (2) @(posedge aclk);
      check("parity cfg", 32'(cfg_parity_on), 32'h1);
      // Upper byte lane alone reaches only the top control bits
      s_axi_wstrb <= 4'h2;
      axi_write(CTRL_OFFS, 32'h0000_03ff, wrsp);
      s_axi_wstrb <= 4'hf;
      axi_read(CTRL_OFFS, rdat, rrsp);
      check("ctrl lane write", rdat, 32'h0000_0304);
      // Power-down and pin wake-up, masks open then closed
      for (int k = 0; k < 2; k++) begin
         wctrl = (k == 0) ? 10'h3f8 : 10'h078;
         axi_write(CTRL_OFFS, 32'(wctrl), wrsp);
         uart_clk_on <= 1'b0; // Clock stops only with no frame under way
         repeat (3) @(posedge aclk);
         check("xfer paused", 32'(xfer_run), 32'h0);
         axi_read(STAT_OFFS, rdat, rrsp);
         check("power off", 32'(rdat[2:1]), 32'h1);
         axi_read(CTRL_OFFS, rdat, rrsp);
         check("ctrl kept", rdat, 32'(wctrl));
         axi_read(DATA_OFFS, rdat, rrsp);
         check("data kept", rdat, 32'h0ff);
         base_irq = irq_cnt;
         base_wake = wake_cnt;
         send(9'h1ff);
         for (int i = 0; i < 20 && wake_cnt == base_wake; i++) @(posedge aclk);
         check("wake event", wake_cnt - base_wake, 32'h1);
         // No wake within the bound: the rest cannot be judged
         if (wake_cnt == base_wake) finish_test();
         uart_clk_on <= 1'b1;
         @(negedge aclk);
         check("ignore window", 32'(rx_ignore), 32'h1);
         check("irq early", irq_cnt - base_irq, 32'h0);
         repeat (35) @(posedge aclk);
         check("wake irq", irq_cnt - base_irq, 32'(k == 0));
         check("ignore over", 32'(rx_ignore), 32'h0);
         check("xfer resumed", 32'(xfer_run), 32'h1);
         axi_read(STAT_OFFS, rdat, rrsp);
         check("word ignored", 32'(rdat[SB_FLAG]), 32'h0);
      end
      // Second reset in mid-run
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(CTRL_OFFS, rdat, rrsp);
      check("ctrl after reset", rdat, 32'(CTRL_RST));
      finish_test();
   end
endmodule : tb
